// ---- hdl/iit_issue_ctrl.sv ----
// Issue latency, stall and abort control for multi-cycle instructions
`timescale 1ns/10ps

module iit_issue_ctrl
   import iit_pkg::*;
#(
   parameter int unsigned CNT_W = IIT_CNT_W
)
(
   input  wire logic             i_clock,
   input  wire logic             i_rstn,
   input  wire logic             i_issue_valid,
   input  wire iit_op_type       i_op,
   input  wire logic [CNT_W-1:0] i_reg_count,
   input  wire logic             i_target_bus,
   input  wire logic             i_ptr_update,
   input  wire logic             i_pc_loaded,
   input  wire logic             i_ret_test,
   input  wire logic             i_branch_taken,
   input  wire logic             i_debug_enable,
   input  wire logic             i_from_hp_irq,
   input  wire logic             i_to_status_word,
   input  wire logic             i_wbuf_pending,
   input  wire logic             i_bus_ready,
   input  wire logic             i_irq_pending,
   output logic                  o_ready,
   output logic                  o_mem_ready,
   output logic                  o_stall,
   output logic                  o_done,
   output logic                  o_abort,
   output logic                  o_flush,
   output logic                  o_link_write,
   output logic                  o_dbg_addr_write,
   output logic                  o_dbg_restore,
   output logic                  o_xfer,
   output logic                  o_xfer_write,
   output logic                  o_lock,
   output logic                  o_lock_write,
   output logic                  o_rmw_busy
);

   // ==========================================================
   // Decode helpers
   // ==========================================================
   function automatic logic is_multi(input iit_op_type op);
      is_multi = (op == IIT_OP_LDM) || (op == IIT_OP_TASK_SWITCH_LOAD) ||
                 (op == IIT_OP_POPM) || (op == IIT_OP_PUSHM) ||
                 (op == IIT_OP_STM) || (op == IIT_OP_STMTS);
   endfunction

   function automatic logic is_mload(input iit_op_type op);
      is_mload = (op == IIT_OP_LDM) || (op == IIT_OP_TASK_SWITCH_LOAD) ||
                 (op == IIT_OP_POPM);
   endfunction

   function automatic logic is_mem(input iit_op_type op);
      is_mem = is_multi(op) || (op == IIT_OP_MEM) ||
               (op == IIT_OP_XCHG) || (op == IIT_OP_RMW);
   endfunction

   function automatic logic is_abortable(input iit_op_type op);
      is_abortable = is_multi(op) || (op == IIT_OP_RETE);
   endfunction

   // Issue latency of one instruction
   function automatic logic [7:0] latency(
      input iit_op_type op, input logic [CNT_W-1:0] n, input logic bus,
      input logic ptr, input logic pc, input logic rtest,
      input logic taken, input logic dbg, input logic hp,
      input logic sw, input logic wbuf);
      logic [7:0] nw;
      logic [7:0] lat;
      nw  = 8'(n);
      lat = IIT_LAT_ONE;
      unique case (op)
         IIT_OP_LDM, IIT_OP_TASK_SWITCH_LOAD, IIT_OP_POPM:
         begin
            if (bus)
               lat = IIT_LAT_ONE + nw + nw;
            else if (ptr || op == IIT_OP_POPM)
               lat = IIT_LAT_TWO + nw;
            else
               lat = IIT_LAT_ONE + nw;
            if (pc && op != IIT_OP_TASK_SWITCH_LOAD)
            begin
               lat = lat + IIT_PC_EXTRA;
               if (rtest)
                  lat = lat + IIT_RET_TEST_EXTRA;
            end
         end
         IIT_OP_PUSHM:
            lat = (bus ? IIT_LAT_THREE : IIT_LAT_TWO) + nw;
         IIT_OP_STM, IIT_OP_STMTS:
         begin
            lat = (ptr ? IIT_LAT_TWO : IIT_LAT_ONE) + nw;
            if (bus)
               lat = lat + IIT_LAT_ONE;
         end
         IIT_OP_BRANCH:
            lat = taken ? IIT_LAT_ONE + IIT_BR_PENALTY
                        : IIT_LAT_ONE;
         IIT_OP_CALL:    lat = IIT_LAT_CALL;
         IIT_OP_BREAK:   lat = dbg ? IIT_LAT_BREAK_DBG : IIT_LAT_ONE;
         IIT_OP_RETD:    lat = IIT_LAT_RETD;
         IIT_OP_RETE:    lat = hp ? IIT_LAT_RETE_HP : IIT_LAT_RETE;
         IIT_OP_RETS:    lat = IIT_LAT_RETS;
         IIT_OP_XCHG:    lat = IIT_LAT_XCHG;
         IIT_OP_MTSR:    lat = sw ? IIT_LAT_MTSR_SW : IIT_LAT_ONE;
         IIT_OP_SYSMOVE: lat = IIT_LAT_ONE;
         IIT_OP_SYSCTL:  lat = IIT_LAT_ONE;
         IIT_OP_RMW:
            lat = (!bus && wbuf) ? IIT_LAT_RMW_WBUF
                                 : IIT_LAT_ONE;
         default:
            lat = IIT_LAT_ONE;
      endcase
      latency = lat;
   endfunction

   // ==========================================================
   // Reset release
   // ==========================================================
   logic rst_meta_r;
   logic rstn_s;

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         rst_meta_r <= 1'b0;
         rstn_s     <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rstn_s     <= rst_meta_r;
      end
   end

   // ==========================================================
   // Declarations
   // ==========================================================
   iit_state_type    state_r;
   iit_state_type    state_nxt;
   iit_op_type       op_r;
   logic [7:0]       cnt_r;
   logic [7:0]       cnt_nxt;
   logic [7:0]       lat_in;
   logic [CNT_W-1:0] words_r;
   logic [1:0]       bg_r;
   logic [1:0]       bg_nxt;
   logic             bus_r;
   logic             flow_r;
   logic             phase_r;
   logic             accept;
   logic             busy;
   logic             stall_now;
   logic             abort_nxt;
   logic             done_nxt;
   logic             flow_in;
   logic             xfer_now;

   assign busy   = (state_r == IIT_ST_BUSY);
   assign accept = o_ready && i_issue_valid &&
                   (!is_mem(i_op) || o_mem_ready);
   assign lat_in = latency(i_op, i_reg_count, i_target_bus,
                           i_ptr_update, i_pc_loaded, i_ret_test,
                           i_branch_taken, i_debug_enable,
                           i_from_hp_irq, i_to_status_word,
                           i_wbuf_pending);

   // Bus busy or wait states freeze the count of multiple accesses to the bus
   assign stall_now = busy && is_multi(op_r) && bus_r &&
                      !i_bus_ready;

   // Change of flow at the end of the instruction
   assign flow_in = (i_op == IIT_OP_BRANCH && i_branch_taken) ||
                    (i_op == IIT_OP_CALL) ||
                    (i_op == IIT_OP_BREAK && i_debug_enable) ||
                    (i_op == IIT_OP_RETD) || (i_op == IIT_OP_RETE) ||
                    (i_op == IIT_OP_RETS) ||
                    (is_mload(i_op) && i_pc_loaded);

   // ==========================================================
   // Latency counter
   // ==========================================================
   always_comb
   begin
      cnt_nxt   = cnt_r;
      abort_nxt = 1'b0;
      done_nxt  = 1'b0;
      unique case (state_r)
         IIT_ST_IDLE:
         begin
            if (accept)
            begin
               if (is_abortable(i_op) && i_irq_pending)
               begin
                  cnt_nxt   = IIT_CNT_RST;
                  abort_nxt = 1'b1;
               end
               else
               begin
                  cnt_nxt  = lat_in - IIT_LAT_ONE;
                  done_nxt = (lat_in == IIT_LAT_ONE);
               end
            end
         end
         IIT_ST_BUSY:
         begin
            if (is_abortable(op_r) && i_irq_pending)
            begin
               cnt_nxt   = IIT_CNT_RST;
               abort_nxt = 1'b1;
            end
            else if (!stall_now)
            begin
               cnt_nxt  = cnt_r - IIT_LAT_ONE;
               done_nxt = (cnt_r == IIT_LAT_ONE);
            end
         end
      endcase
      state_nxt = (cnt_nxt != IIT_CNT_RST) ? IIT_ST_BUSY : IIT_ST_IDLE;
   end

   always_ff @(posedge i_clock or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         state_r <= IIT_ST_IDLE;
         cnt_r   <= IIT_CNT_RST;
         o_ready <= 1'b1;
         o_done  <= 1'b0;
         o_abort <= 1'b0;
         o_stall <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         o_ready <= (state_nxt == IIT_ST_IDLE);
         o_done  <= done_nxt;
         o_abort <= abort_nxt;
         o_stall <= stall_now;
      end
   end

   // ==========================================================
   // Instruction context
   // ==========================================================
   always_ff @(posedge i_clock or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         op_r   <= IIT_OP_ALU;
         bus_r  <= 1'b0;
         flow_r <= 1'b0;
      end
      else if (accept)
      begin
         op_r   <= i_op;
         bus_r  <= i_target_bus;
         flow_r <= flow_in;
      end
   end

   // ==========================================================
   // Completion effects
   // ==========================================================
   always_ff @(posedge i_clock or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         o_flush          <= 1'b0;
         o_link_write     <= 1'b0;
         o_dbg_addr_write <= 1'b0;
         o_dbg_restore    <= 1'b0;
      end
      else if (accept)
      begin
         o_flush          <= done_nxt && flow_in;
         o_link_write     <= done_nxt && (i_op == IIT_OP_CALL);
         o_dbg_addr_write <= done_nxt && (i_op == IIT_OP_BREAK) &&
                             i_debug_enable;
         o_dbg_restore    <= done_nxt && (i_op == IIT_OP_RETD);
      end
      else
      begin
         o_flush          <= done_nxt && flow_r;
         o_link_write     <= done_nxt && (op_r == IIT_OP_CALL);
         o_dbg_addr_write <= done_nxt && (op_r == IIT_OP_BREAK);
         o_dbg_restore    <= done_nxt && (op_r == IIT_OP_RETD);
      end
   end

   // ==========================================================
   // Word transfers of multiple accesses
   // ==========================================================
   // Bus loads take two cycles per word, other transfers one
   assign xfer_now = busy && (words_r != IIT_WRD_RST) && !abort_nxt &&
                     !stall_now &&
                     (!(bus_r && is_mload(op_r)) || phase_r);

   always_ff @(posedge i_clock or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         words_r      <= IIT_WRD_RST;
         phase_r      <= 1'b0;
         o_xfer       <= 1'b0;
         o_xfer_write <= 1'b0;
      end
      else
      begin
         o_xfer       <= xfer_now;
         o_xfer_write <= xfer_now && !is_mload(op_r);
         if (accept)
         begin
            words_r <= is_multi(i_op) && !abort_nxt ?
                       i_reg_count : IIT_WRD_RST;
            phase_r <= 1'b0;
         end
         else if (abort_nxt)
            words_r <= IIT_WRD_RST;
         else if (busy && words_r != IIT_WRD_RST && !stall_now)
         begin
            phase_r <= !phase_r;
            if (xfer_now)
               words_r <= words_r - 1'b1;
         end
      end
   end

   // ==========================================================
   // Exchange lock
   // ==========================================================
   always_ff @(posedge i_clock or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         o_lock       <= 1'b0;
         o_lock_write <= 1'b0;
      end
      else
      begin
         o_lock       <= (accept && i_op == IIT_OP_XCHG) ||
                         (busy && op_r == IIT_OP_XCHG &&
                          cnt_nxt != IIT_CNT_RST);
         o_lock_write <= accept && i_op == IIT_OP_XCHG;
      end
   end

   // ==========================================================
   // Bus bit operation background
   // ==========================================================
   always_comb
   begin
      bg_nxt = bg_r;
      if (accept && i_op == IIT_OP_RMW && i_target_bus)
         bg_nxt = IIT_RMW_BUS_BG;
      else if (bg_r != IIT_BG_RST && i_bus_ready)
         bg_nxt = bg_r - 1'b1;
   end

   always_ff @(posedge i_clock or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         bg_r        <= IIT_BG_RST;
         o_mem_ready <= 1'b1;
         o_rmw_busy  <= 1'b0;
      end
      else
      begin
         bg_r        <= bg_nxt;
         o_mem_ready <= (state_nxt == IIT_ST_IDLE) &&
                        (bg_nxt == IIT_BG_RST);
         o_rmw_busy  <= (bg_nxt != IIT_BG_RST);
      end
   end

endmodule

// ---- hdl/iit_pkg.sv ----
// Constants and types for the instruction issue timing controller
package iit_pkg;

   // ==========================================================
   // Widths
   // ==========================================================
   localparam int unsigned IIT_CNT_W  = 5;
   localparam int unsigned IIT_LAT_W  = 8;

   // ==========================================================
   // Issue latencies in cycles
   // ==========================================================
   localparam logic [7:0] IIT_LAT_ONE       = 8'h01;
   localparam logic [7:0] IIT_LAT_TWO       = 8'h02;
   localparam logic [7:0] IIT_LAT_THREE     = 8'h03;
   localparam logic [7:0] IIT_BR_PENALTY    = 8'h02;
   localparam logic [7:0] IIT_LAT_CALL      = 8'h04;
   localparam logic [7:0] IIT_LAT_BREAK_DBG = 8'h03;
   localparam logic [7:0] IIT_LAT_RETD      = 8'h03;
   localparam logic [7:0] IIT_LAT_RETE_HP   = 8'h0c;
   localparam logic [7:0] IIT_LAT_RETE      = 8'h05;
   localparam logic [7:0] IIT_LAT_RETS      = 8'h05;
   localparam logic [7:0] IIT_LAT_XCHG      = 8'h02;
   localparam logic [7:0] IIT_LAT_MTSR_SW   = 8'h03;
   localparam logic [7:0] IIT_LAT_RMW_WBUF  = 8'h02;
   localparam logic [7:0] IIT_PC_EXTRA      = 8'h01;
   localparam logic [7:0] IIT_RET_TEST_EXTRA = 8'h01;

   // Background cycles of a system bus bit operation after issue
   localparam logic [1:0] IIT_RMW_BUS_BG    = 2'h3;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0] IIT_CNT_RST = 8'h00;
   localparam logic [4:0] IIT_WRD_RST = 5'h00;
   localparam logic [1:0] IIT_BG_RST  = 2'h0;

   // ==========================================================
   // Instruction classes
   // ==========================================================
   typedef enum logic [4:0] {
      IIT_OP_ALU     = 5'h00,
      IIT_OP_MEM     = 5'h01,
      IIT_OP_LDM     = 5'h02,
      IIT_OP_TASK_SWITCH_LOAD   = 5'h03,
      IIT_OP_POPM    = 5'h04,
      IIT_OP_PUSHM   = 5'h05,
      IIT_OP_STM     = 5'h06,
      IIT_OP_STMTS   = 5'h07,
      IIT_OP_BRANCH  = 5'h08,
      IIT_OP_CALL    = 5'h09,
      IIT_OP_BREAK   = 5'h0a,
      IIT_OP_RETD    = 5'h0b,
      IIT_OP_RETE    = 5'h0c,
      IIT_OP_RETS    = 5'h0d,
      IIT_OP_XCHG    = 5'h0e,
      IIT_OP_MTSR    = 5'h0f,
      IIT_OP_SYSMOVE = 5'h10,
      IIT_OP_SYSCTL  = 5'h11,
      IIT_OP_RMW     = 5'h12
   } iit_op_type;

   // Controller states
   typedef enum logic [1:0] {
      IIT_ST_IDLE = 2'b01,
      IIT_ST_BUSY = 2'b10
   } iit_state_type;

endpackage

// ---- verif/iit_bus_slave_model.sv ----
// Behavioural system bus slave that inserts a set number of wait states
`timescale 1ns/10ps

module iit_bus_slave_model
(
   input  wire logic       i_clock,
   input  wire logic       i_rstn,
   input  wire logic [3:0] i_wait,
   output logic            o_bus_ready
);

   logic [3:0] wait_cnt_r;

   // ==========================================================
   // Ready low for i_wait cycles, then high for one
   // ==========================================================
   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
         wait_cnt_r <= 4'h0;
      else if (wait_cnt_r >= i_wait)
         wait_cnt_r <= 4'h0;
      else
         wait_cnt_r <= wait_cnt_r + 4'h1;
   end

   assign o_bus_ready = (wait_cnt_r >= i_wait);

endmodule

// ---- verif/iit_issue_ctrl_props.sv ----
// Timing assertions for the instruction issue controller
`timescale 1ns/10ps

module iit_issue_ctrl_props
   import iit_pkg::*;
(
   input wire logic       i_clock,
   input wire logic       i_rstn,
   input wire logic       i_issue_valid,
   input wire iit_op_type i_op,
   input wire logic       i_target_bus,
   input wire logic       i_branch_taken,
   input wire logic       i_to_status_word,
   input wire logic       i_wbuf_pending,
   input wire logic       i_irq_pending,
   input wire logic       o_ready,
   input wire logic       o_mem_ready,
   input wire logic       o_done,
   input wire logic       o_abort,
   input wire logic       o_flush,
   input wire logic       o_link_write,
   input wire logic       o_dbg_restore,
   input wire logic       o_lock,
   input wire logic       o_lock_write,
   input wire logic       o_rmw_busy
);

   logic mem_cls;
   logic acc;
   logic multi;

   assign mem_cls = i_op inside {IIT_OP_MEM, IIT_OP_LDM, IIT_OP_TASK_SWITCH_LOAD,
      IIT_OP_POPM, IIT_OP_PUSHM, IIT_OP_STM, IIT_OP_STMTS, IIT_OP_XCHG,
      IIT_OP_RMW};
   assign multi = i_op inside {IIT_OP_LDM, IIT_OP_TASK_SWITCH_LOAD, IIT_OP_POPM,
      IIT_OP_PUSHM, IIT_OP_STM, IIT_OP_STMTS, IIT_OP_RETE};
   assign acc = o_ready && i_issue_valid && (!mem_cls || o_mem_ready);

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rstn);

   // ==========================================================
   // Latency and side effects
   // ==========================================================
   property p_call;
      acc && i_op == IIT_OP_CALL |=> !o_ready [*3]
         ##1 (o_ready && o_done && o_flush && o_link_write);
   endproperty
   a_call : assert property (p_call) else $error("call timing wrong");

   property p_retd;
      acc && i_op == IIT_OP_RETD |=> !o_ready [*2]
         ##1 (o_done && o_dbg_restore);
   endproperty
   a_retd : assert property (p_retd) else $error("retd timing wrong");

   property p_mtsr;
      acc && i_op == IIT_OP_MTSR && i_to_status_word
         |=> !o_ready [*2] ##1 o_done;
   endproperty
   a_mtsr : assert property (p_mtsr) else $error("mtsr timing wrong");

   property p_xchg;
      acc && i_op == IIT_OP_XCHG |=> (o_lock && o_lock_write)
         ##1 (o_done && !o_lock);
   endproperty
   a_xchg : assert property (p_xchg) else $error("xchg lock wrong");

   property p_br_nt;
      acc && i_op == IIT_OP_BRANCH && !i_branch_taken |=> o_done && !o_flush;
   endproperty
   a_br_nt : assert property (p_br_nt) else $error("branch wrong");

   property p_br_tk;
      acc && i_op == IIT_OP_BRANCH && i_branch_taken
         |=> !o_ready [*2] ##1 (o_done && o_flush);
   endproperty
   a_br_tk : assert property (p_br_tk) else $error("taken wrong");

   property p_abort;
      acc && multi && i_irq_pending |=> o_abort && o_ready && !o_done;
   endproperty
   a_abort : assert property (p_abort) else $error("no abort");

   property p_abort_excl;
      o_abort |-> !o_done && !o_flush && !o_link_write;
   endproperty
   a_abort_excl : assert property (p_abort_excl) else $error("abort+done");

   property p_rmw_bus;
      acc && i_op == IIT_OP_RMW && i_target_bus
         |=> o_rmw_busy && !o_mem_ready && o_ready;
   endproperty
   a_rmw_bus : assert property (p_rmw_bus) else $error("rmw bus wrong");

   property p_rmw_loc;
      acc && i_op == IIT_OP_RMW && !i_target_bus && !i_wbuf_pending
         |=> o_done && !o_rmw_busy;
   endproperty
   a_rmw_loc : assert property (p_rmw_loc) else $error("rmw local wrong");

   property p_flush_done;
      o_flush |-> o_done;
   endproperty
   a_flush_done : assert property (p_flush_done) else $error("lone flush");

endmodule

bind iit_issue_ctrl iit_issue_ctrl_props u_props
(
   .i_clock(i_clock), .i_rstn(i_rstn), .i_issue_valid(i_issue_valid),
   .i_op(i_op), .i_target_bus(i_target_bus),
   .i_branch_taken(i_branch_taken), .i_to_status_word(i_to_status_word),
   .i_wbuf_pending(i_wbuf_pending), .i_irq_pending(i_irq_pending),
   .o_ready(o_ready), .o_mem_ready(o_mem_ready), .o_done(o_done),
   .o_abort(o_abort), .o_flush(o_flush), .o_link_write(o_link_write),
   .o_dbg_restore(o_dbg_restore), .o_lock(o_lock),
   .o_lock_write(o_lock_write), .o_rmw_busy(o_rmw_busy)
);

// ---- verif/tb_top.sv ----
// Self-checking bench for the instruction issue timing controller
`timescale 1ns/10ps

module tb_top
   import iit_pkg::*;
;

   typedef struct packed {
      iit_op_type op;
      logic [4:0] n;
      logic [8:0] f;
      logic [7:0] lat;
      logic [2:0] fl;
   } iit_row_type;

   logic       i_clock, i_rstn, i_issue_valid, i_target_bus, i_ptr_update;
   logic       i_pc_loaded, i_ret_test, i_branch_taken, i_debug_enable;
   logic       i_from_hp_irq, i_to_status_word, i_wbuf_pending;
   logic       i_bus_ready, i_irq_pending;
   iit_op_type i_op;
   logic [4:0] i_reg_count;
   logic [3:0] bus_wait;
   logic       o_ready, o_mem_ready, o_stall, o_done, o_abort, o_flush;
   logic       o_link_write, o_dbg_addr_write, o_dbg_restore, o_xfer;
   logic       o_xfer_write, o_lock, o_lock_write, o_rmw_busy;
   int         fail_count, num_checks, cyc, k;

   // Flag bits: bus ptr pc rtest taken dbg hp sw wbuf
   iit_row_type rows[35] = '{
      '{IIT_OP_LDM,5'h04,9'h000,8'h05,3'h0},
      '{IIT_OP_LDM,5'h04,9'h080,8'h06,3'h0},
      '{IIT_OP_LDM,5'h04,9'h100,8'h09,3'h0},
      '{IIT_OP_LDM,5'h1f,9'h100,8'h3f,3'h0},
      '{IIT_OP_TASK_SWITCH_LOAD,5'h03,9'h000,8'h04,3'h0},
      '{IIT_OP_TASK_SWITCH_LOAD,5'h03,9'h080,8'h05,3'h0},
      '{IIT_OP_TASK_SWITCH_LOAD,5'h03,9'h100,8'h07,3'h0},
      '{IIT_OP_LDM,5'h02,9'h040,8'h04,3'h0},
      '{IIT_OP_LDM,5'h02,9'h060,8'h05,3'h0},
      '{IIT_OP_LDM,5'h02,9'h020,8'h03,3'h0},
      '{IIT_OP_POPM,5'h03,9'h000,8'h05,3'h0},
      '{IIT_OP_POPM,5'h03,9'h100,8'h07,3'h0},
      '{IIT_OP_POPM,5'h03,9'h060,8'h07,3'h0},
      '{IIT_OP_PUSHM,5'h03,9'h000,8'h05,3'h0},
      '{IIT_OP_PUSHM,5'h03,9'h100,8'h06,3'h0},
      '{IIT_OP_PUSHM,5'h01,9'h000,8'h03,3'h0},
      '{IIT_OP_STM,5'h02,9'h000,8'h03,3'h0},
      '{IIT_OP_STM,5'h02,9'h080,8'h04,3'h0},
      '{IIT_OP_STM,5'h02,9'h100,8'h04,3'h0},
      '{IIT_OP_STM,5'h02,9'h180,8'h05,3'h0},
      '{IIT_OP_STMTS,5'h01,9'h080,8'h03,3'h0},
      '{IIT_OP_BRANCH,5'h00,9'h000,8'h01,3'h0},
      '{IIT_OP_BRANCH,5'h00,9'h010,8'h03,3'h0},
      '{IIT_OP_CALL,5'h00,9'h000,8'h04,3'h4},
      '{IIT_OP_BREAK,5'h00,9'h000,8'h01,3'h0},
      '{IIT_OP_BREAK,5'h00,9'h008,8'h03,3'h2},
      '{IIT_OP_RETD,5'h00,9'h000,8'h03,3'h1},
      '{IIT_OP_RETE,5'h00,9'h000,8'h05,3'h0},
      '{IIT_OP_RETE,5'h00,9'h004,8'h0c,3'h0},
      '{IIT_OP_RETS,5'h00,9'h000,8'h05,3'h0},
      '{IIT_OP_XCHG,5'h00,9'h000,8'h02,3'h0},
      '{IIT_OP_MTSR,5'h00,9'h002,8'h03,3'h0},
      '{IIT_OP_MTSR,5'h00,9'h000,8'h01,3'h0},
      '{IIT_OP_SYSMOVE,5'h00,9'h000,8'h01,3'h0},
      '{IIT_OP_SYSCTL,5'h00,9'h000,8'h01,3'h0}
   };

   iit_bus_slave_model u_slave
   (
      .i_clock(i_clock), .i_rstn(i_rstn), .i_wait(bus_wait),
      .o_bus_ready(i_bus_ready)
   );

   iit_issue_ctrl u_dut
   (
      .i_clock(i_clock), .i_rstn(i_rstn), .i_issue_valid(i_issue_valid),
      .i_op(i_op), .i_reg_count(i_reg_count), .i_target_bus(i_target_bus),
      .i_ptr_update(i_ptr_update), .i_pc_loaded(i_pc_loaded),
      .i_ret_test(i_ret_test), .i_branch_taken(i_branch_taken),
      .i_debug_enable(i_debug_enable), .i_from_hp_irq(i_from_hp_irq),
      .i_to_status_word(i_to_status_word), .i_wbuf_pending(i_wbuf_pending),
      .i_bus_ready(i_bus_ready), .i_irq_pending(i_irq_pending),
      .o_ready(o_ready), .o_mem_ready(o_mem_ready), .o_stall(o_stall),
      .o_done(o_done), .o_abort(o_abort), .o_flush(o_flush),
      .o_link_write(o_link_write), .o_dbg_addr_write(o_dbg_addr_write),
      .o_dbg_restore(o_dbg_restore), .o_xfer(o_xfer),
      .o_xfer_write(o_xfer_write), .o_lock(o_lock),
      .o_lock_write(o_lock_write), .o_rmw_busy(o_rmw_busy)
   );

   // ==========================================================
   // Clock and timeout
   // ==========================================================
   initial
   begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end

   always @(posedge i_clock)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fail_count++;
         end_sim();
      end
   end

   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic drive(input iit_row_type r);
      @(negedge i_clock);
      i_issue_valid = 1'b1;
      i_op = r.op;
      i_reg_count = r.n;
      {i_target_bus, i_ptr_update, i_pc_loaded, i_ret_test, i_branch_taken,
         i_debug_enable, i_from_hp_irq, i_to_status_word,
         i_wbuf_pending} = r.f;
   endtask

   // Issue one instruction, measure latency, words and stalls
   task automatic run(input iit_row_type r);
      int lat, lows, xf, st;
      drive(r);
      @(negedge i_clock);
      i_issue_valid = 1'b0;
      lat = 1;
      lows = 0;
      xf = 0;
      st = 0;
      while (o_done !== 1'b1 && lat < 200)
      begin
         if (!o_ready && !i_bus_ready) lows++;
         if (o_xfer === 1'b1) xf += o_xfer_write ? 32 : 1;
         if (o_stall === 1'b1) st++;
         @(negedge i_clock);
         lat++;
      end
      if (o_xfer === 1'b1) xf += o_xfer_write ? 32 : 1;
      check(16'(lat), 16'(r.lat) + 16'(lows));
      check({o_link_write, o_dbg_addr_write, o_dbg_restore}, r.fl);
      check(16'(st), 16'(lows));
      if (r.op inside {IIT_OP_LDM, IIT_OP_TASK_SWITCH_LOAD, IIT_OP_POPM, IIT_OP_PUSHM,
            IIT_OP_STM, IIT_OP_STMTS})
         check(16'(xf), 16'(r.n) * (r.op inside {IIT_OP_LDM, IIT_OP_TASK_SWITCH_LOAD,
            IIT_OP_POPM} ? 16'h1 : 16'h20));
      if (r.op inside {IIT_OP_BRANCH, IIT_OP_CALL, IIT_OP_LDM, IIT_OP_POPM})
         check(o_flush, r.op == IIT_OP_CALL || r.f[4] || r.f[6]);
   endtask

   // Raise a pending interrupt dly cycles after accept
   task automatic abort_case(input iit_row_type r, input int dly);
      drive(r);
      i_irq_pending = (dly == 0);
      for (k = 1; k <= dly + 1; k++)
      begin
         @(negedge i_clock);
         i_issue_valid = 1'b0;
         if (k == dly) i_irq_pending = 1'b1;
      end
      check({o_abort, o_done, o_ready}, 3'b101);
      i_irq_pending = 1'b0;
   endtask

   // Count cycles that memory instructions are held off
   task automatic mem_hold(input logic [15:0] exp);
      int n;
      n = 0;
      while (o_mem_ready !== 1'b1 && n < 20)
      begin
         check(o_ready, 1'b1);
         n++;
         @(negedge i_clock);
      end
      check(16'(n), exp);
   endtask

   task automatic end_sim();
      $display("TB: checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial
   begin
      {i_issue_valid, i_target_bus, i_ptr_update, i_pc_loaded} = 4'h0;
      {i_ret_test, i_branch_taken, i_debug_enable, i_from_hp_irq} = 4'h0;
      {i_to_status_word, i_wbuf_pending, i_irq_pending} = 3'h0;
      i_op = IIT_OP_ALU;
      i_reg_count = 5'h00;
      bus_wait = 4'h0;
      i_rstn = 1'b0;
      fail_count = 0;
      num_checks = 0;
      cyc = 0;
      repeat (3) @(negedge i_clock);
      check({o_ready, o_mem_ready, o_stall, o_done, o_abort, o_flush,
         o_link_write, o_dbg_addr_write, o_dbg_restore, o_xfer, o_xfer_write,
         o_lock, o_lock_write, o_rmw_busy}, 16'h3000);
      i_rstn = 1'b1;
      repeat (3) @(posedge i_clock);
      $display("TB: reset test done");
      foreach (rows[i]) run(rows[i]);
      run('{IIT_OP_RMW, 5'h00, 9'h000, 8'h01, 3'h0});
      run('{IIT_OP_RMW, 5'h00, 9'h001, 8'h02, 3'h0});
      $display("TB: table test done");
      run('{IIT_OP_RMW, 5'h00, 9'h100, 8'h01, 3'h0});
      mem_hold(16'h0003);
      run('{IIT_OP_RMW, 5'h00, 9'h100, 8'h01, 3'h0});
      run('{IIT_OP_ALU, 5'h00, 9'h000, 8'h01, 3'h0});
      mem_hold(16'h0001);
      $display("TB: bit operation test done");
      bus_wait = 4'h2;
      run('{IIT_OP_LDM, 5'h03, 9'h100, 8'h07, 3'h0});
      run('{IIT_OP_STM, 5'h03, 9'h180, 8'h06, 3'h0});
      bus_wait = 4'h0;
      $display("TB: wait state test done");
      abort_case('{IIT_OP_LDM, 5'h08, 9'h000, 8'h00, 3'h0}, 0);
      abort_case('{IIT_OP_PUSHM, 5'h08, 9'h000, 8'h00, 3'h0}, 2);
      abort_case('{IIT_OP_STM, 5'h08, 9'h100, 8'h00, 3'h0}, 4);
      abort_case('{IIT_OP_RETE, 5'h00, 9'h000, 8'h00, 3'h0}, 3);
      abort_case('{IIT_OP_RETE, 5'h00, 9'h004, 8'h00, 3'h0}, 0);
      $display("TB: abort test done");
      end_sim();
   end

endmodule
